// [src/i2c_addr_bitrate_cfg.sv]
`timescale 1ns/1ps
module i2c_addr_bitrate_cfg
  import i2c_cfg_pkg::*;
(
  input  wire logic        core_clk_i,  // 100 MHz system clock
  input  wire logic        nrst_i,      // Async reset, active low
  input  wire reg_req_t    req_i,       // Register access
  output logic [31:0]      rdata_o,     // Read data
  output logic             bus_ack_o,   // Access answered
  output logic             err_o,       // Access refused
  input  wire logic        scl_i,       // SCL level
  output logic             scl_o,       // SCL drive value (low)
  output logic             scl_oe_o,    // SCL pulled low
  input  wire logic        sda_i,       // SDA level
  output logic             sda_o,       // SDA drive value (low)
  output logic             sda_oe_o     // SDA pulled low
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]  own_q, own_d;      // Own slave address
  logic [7:0]  rate_q, rate_d;    // Rate code
  logic [7:0]  ctl_q, ctl_d;      // Control
  logic [7:0]  data_q, data_d;    // Data byte
  logic [31:0] rdata_q, rdata_d;  // Read answer
  logic        err_q, err_d;      // Refusal flag
  logic        back_q, back_d;    // Access answered
  logic [4:0]  sel;               // One-hot register select
  logic [7:0]  rd_byte;           // Selected register value
  logic [7:0]  status;            // Live status byte
  // Link state
  logic [DIV_W-1:0] cnt_q, cnt_d; // Prescaler count
  logic        tick;              // Half bit period elapsed
  mst_state_t  mst_q, mst_d;      // Master sequencer
  logic [3:0]  mbit_q, mbit_d;    // Master bit index
  logic [7:0]  tx_q, tx_d;        // Byte being shifted out
  logic        sclk_q, sclk_d;    // Master holds SCL low
  logic        msda_q, msda_d;    // Master holds SDA low
  logic        scl_s_q, sda_s_q;  // Previous line samples
  logic        busy_q, busy_d;    // Bus between start and stop
  logic [7:0]  sh_q, sh_d;        // Slave shift register
  logic [3:0]  sbit_q, sbit_d;    // Slave bit count
  logic        sadr_q, sadr_d;    // Slave in address phase
  logic        sack_q, sack_d;    // Slave pulling acknowledge
  logic        aas_q, aas_d;      // Addressed as slave
  logic        srw_q, srw_d;      // Requested direction
  logic        tcf_q, tcf_d;      // Byte transfer complete
  logic        rxak_q, rxak_d;    // Acknowledge received
  logic        scl_rise, scl_fall, start_det, stop_det, match, wr_data;

  // Register select, unmapped offsets give all zero
  always_comb begin
    sel = 5'b00000;
    if (req_i.addr == OFS_OWN_ADDR) begin
      sel = 5'b00001;
    end else if (req_i.addr == OFS_RATE) begin
      sel = 5'b00010;
    end else if (req_i.addr == OFS_CTRL) begin
      sel = 5'b00100;
    end else if (req_i.addr == OFS_STATUS) begin
      sel = 5'b01000;
    end else if (req_i.addr == OFS_DATA) begin
      sel = 5'b10000;
    end
  end

  assign status  = {tcf_q, aas_q, busy_q, 2'b00, srw_q, 1'b0, rxak_q};
  assign wr_data = req_i.wr && sel[4];

  // Register next values; writes mask reserved bits to zero
  always_comb begin
    own_d   = (req_i.wr && sel[0]) ? (req_i.wdata[31:24] & ADDR_WR_MASK) : own_q;
    rate_d  = (req_i.wr && sel[1]) ? (req_i.wdata[31:24] & RATE_WR_MASK) : rate_q;
    ctl_d   = (req_i.wr && sel[2]) ? (req_i.wdata[31:24] & CTRL_WR_MASK) : ctl_q;
    data_d  = wr_data ? req_i.wdata[31:24] : data_q;
    rd_byte = 8'h00;
    if (sel[0]) begin
      rd_byte = own_q;
    end else if (sel[1]) begin
      rd_byte = rate_q;
    end else if (sel[2]) begin
      rd_byte = ctl_q;
    end else if (sel[3]) begin
      rd_byte = status;
    end else if (sel[4]) begin
      rd_byte = data_q;
    end
    // Lower lanes are reserved and read as zero
    rdata_d = req_i.rd ? {rd_byte, 24'h000000} : 32'h00000000;
    // Any master, external or not, reaches the five registers;
    // every other offset (memories, base register) is refused
    err_d   = (req_i.rd || req_i.wr) && (sel == 5'b00000);
    back_d  = req_i.rd || req_i.wr;
  end

  // ----------------------------------------------------------------
  // Prescaler and line sampling
  // ----------------------------------------------------------------
  assign tick      = (cnt_q >= half_period(rate_q[5:0]) - 12'd1);
  assign scl_rise  = scl_i && !scl_s_q;
  assign scl_fall  = !scl_i && scl_s_q;
  assign start_det = scl_i && scl_s_q && sda_s_q && !sda_i;
  assign stop_det  = scl_i && scl_s_q && !sda_s_q && sda_i;
  // The block never answers its own call while mastering
  assign match     = (sh_q[7:1] == own_q[7:1]) && (mst_q == M_IDLE);

  // Link next-state logic
  always_comb begin
    // A rate write restarts the period so no stale count survives
    cnt_d  = ((req_i.wr && sel[1]) || tick) ? '0 : cnt_q + 12'd1;
    busy_d = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_q);
    mst_d  = mst_q;
    mbit_d = mbit_q;
    tx_d   = tx_q;
    sclk_d = sclk_q;
    msda_d = msda_q;
    tcf_d  = tcf_q;
    rxak_d = (scl_rise && mst_q == M_XFER && mbit_q == BIT_ACK) ? sda_i : rxak_q;
    case (mst_q)
      M_IDLE: begin
        // Address byte comes from the data register, never own_q
        if (ctl_q[CTL_EN] && ctl_q[CTL_MSTA] && !busy_q && wr_data) begin
          tx_d   = req_i.wdata[31:24];
          msda_d = 1'b1;                // Start: SDA falls, SCL high
          tcf_d  = 1'b0;
          mst_d  = M_START;
        end
      end
      M_START: begin
        if (tick) begin
          sclk_d = 1'b1;
          mbit_d = 4'h0;
          msda_d = ctl_q[CTL_MTX] ? !tx_q[7] : 1'b0;
          mst_d  = M_XFER;
        end
      end
      M_XFER: begin
        if (tick && sclk_q) begin
          sclk_d = 1'b0;                // Low phase over, release SCL
        end else if (tick && scl_i) begin
          // High phase over; a stretched SCL simply delays this
          sclk_d = 1'b1;
          mbit_d = mbit_q + 4'h1;
          tx_d   = {tx_q[6:0], 1'b0};
          if (mbit_q == BIT_ACK) begin
            msda_d = 1'b0;
            tcf_d  = 1'b1;
            mst_d  = M_WAIT;
          end else if (mbit_q == 4'h7) begin
            msda_d = ctl_q[CTL_MTX] ? 1'b0 : !ctl_q[CTL_TXAK];
          end else begin
            msda_d = ctl_q[CTL_MTX] ? !tx_q[6] : 1'b0;
          end
        end
      end
      M_WAIT: begin
        // SCL held low until software supplies the next byte
        if (!ctl_q[CTL_MSTA]) begin
          msda_d = 1'b1;
          mbit_d = 4'h0;
          mst_d  = M_STOP;
        end else if (wr_data) begin
          tx_d   = req_i.wdata[31:24];
          tcf_d  = 1'b0;
          mbit_d = 4'h0;
          msda_d = ctl_q[CTL_MTX] ? !req_i.wdata[31] : 1'b0;
          mst_d  = M_XFER;
        end
      end
      M_STOP: begin
        if (tick && mbit_q == 4'h0) begin
          sclk_d = 1'b0;                // SCL rises first
          mbit_d = 4'h1;
        end else if (tick) begin
          msda_d = 1'b0;                // Then SDA rises: stop
          mst_d  = M_IDLE;
        end
      end
      default: begin
        mst_d = M_IDLE;
      end
    endcase
    if (!ctl_q[CTL_EN]) begin
      mst_d  = M_IDLE;
      sclk_d = 1'b0;
      msda_d = 1'b0;
    end
    // Fresh count on every state change, so start, stop and
    // resumed bytes never move SDA on the edge that moves SCL
    if (mst_d != mst_q) begin
      cnt_d = '0;
    end
  end

  // Slave address reception and acknowledge
  always_comb begin
    sh_d   = sh_q;
    sbit_d = sbit_q;
    sadr_d = sadr_q;
    sack_d = sack_q;
    srw_d  = srw_q;
    aas_d  = aas_q;
    if (req_i.wr && sel[2]) begin
      aas_d = 1'b0;                     // Cleared by a control write
    end
    if (!ctl_q[CTL_EN] || stop_det) begin
      sadr_d = 1'b0;
      sack_d = 1'b0;
    end else if (start_det) begin
      sbit_d = 4'h0;
      sadr_d = 1'b1;
      sack_d = 1'b0;
    end else if (scl_rise && sadr_q && sbit_q < BIT_ACK) begin
      sh_d   = {sh_q[6:0], sda_i};
      sbit_d = sbit_q + 4'h1;
    end else if (scl_fall && sadr_q && sbit_q == BIT_ACK) begin
      sadr_d = 1'b0;
      if (match) begin
        sack_d = 1'b1;
        aas_d  = 1'b1;                  // Set wins over the clear
        srw_d  = sh_q[0];
      end
    end else if (scl_fall && sack_q) begin
      sack_d = 1'b0;                    // Ninth clock finished
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      own_q <= RST_REG;  rate_q <= RST_REG;  ctl_q <= RST_REG;  data_q <= RST_REG;
      rdata_q <= 32'h00000000;  err_q <= 1'b0;  back_q <= 1'b0;
      cnt_q <= '0;  mst_q <= M_IDLE;  mbit_q <= 4'h0;  tx_q <= 8'h00;
      sclk_q <= 1'b0;  msda_q <= 1'b0;  scl_s_q <= 1'b1;  sda_s_q <= 1'b1;
      busy_q <= 1'b0;  sh_q <= 8'h00;  sbit_q <= 4'h0;  sadr_q <= 1'b0;
      sack_q <= 1'b0;  aas_q <= 1'b0;  srw_q <= 1'b0;  tcf_q <= 1'b0;
      rxak_q <= 1'b1;  scl_oe_o <= 1'b0;  sda_oe_o <= 1'b0;
    end else begin
      own_q <= own_d;  rate_q <= rate_d;  ctl_q <= ctl_d;  data_q <= data_d;
      rdata_q <= rdata_d;  err_q <= err_d;  back_q <= back_d;
      cnt_q <= cnt_d;  mst_q <= mst_d;  mbit_q <= mbit_d;  tx_q <= tx_d;
      sclk_q <= sclk_d;  msda_q <= msda_d;  scl_s_q <= scl_i;  sda_s_q <= sda_i;
      busy_q <= busy_d;  sh_q <= sh_d;  sbit_q <= sbit_d;  sadr_q <= sadr_d;
      sack_q <= sack_d;  aas_q <= aas_d;  srw_q <= srw_d;  tcf_q <= tcf_d;
      rxak_q <= rxak_d;
      scl_oe_o <= sclk_d;               // Open drain: enable means low
      // Master SDA lags SCL by one cycle: data changes only while SCL is low
      sda_oe_o <= msda_q || sack_d;
    end
  end

  assign rdata_o   = rdata_q;
  assign err_o     = err_q;
  assign bus_ack_o = back_q;
  assign scl_o     = 1'b0;              // Lines are only ever pulled low
  assign sda_o     = 1'b0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence mapped_read;
    req_i.rd && (sel != 5'b00000);
  endsequence
  sequence addr_done;
    scl_fall && sadr_q && sbit_q == BIT_ACK && ctl_q[CTL_EN] && !start_det && !stop_det;
  endsequence

  lane_zero_a: assert property (mapped_read |=> rdata_o[23:0] == 24'h000000 && !err_o)
    else $error("Reserved lanes not zero");
  own_read_a: assert property (req_i.rd && req_i.addr == OFS_OWN_ADDR |=> rdata_o[31:24] == $past(own_q))
    else $error("Own address read wrong");
  unmapped_err_a: assert property ((req_i.rd || req_i.wr) && sel == 5'b00000 |=> err_o && bus_ack_o)
    else $error("Unmapped access not refused");
  ext_reach_a: assert property (req_i.ext && req_i.wr && sel != 5'b00000 |=> !err_o)
    else $error("External access refused");
  addr_source_a: assert property (mst_q == M_IDLE && mst_d == M_START |=> tx_q == data_q)
    else $error("Calling address not from data path");
  slave_ack_a: assert property (addr_done and match |=> sack_q && aas_q && sda_oe_o)
    else $error("Matching call not acknowledged");
  no_ack_a: assert property (addr_done and !match |=> !sack_q)
    else $error("Acknowledge without match");
  rate_reload_a: assert property (req_i.wr && sel[1] |=> cnt_q == '0)
    else $error("Prescaler not reloaded");
  count_bound_a: assert property (cnt_q < half_period(rate_q[5:0]))
    else $error("Prescaler overran half period");
  tick_period_a: assert property ($rose(tick) && !$past(req_i.wr) |-> $past(cnt_q) == half_period(rate_q[5:0]) - 12'd2)
    else $error("Half period wrong");

endmodule : i2c_addr_bitrate_cfg

// [src/i2c_cfg_pkg.sv]
package i2c_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets from the module base)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_OWN_ADDR = 12'h280;  // own_slave_address
  localparam logic [11:0] OFS_RATE     = 12'h284;  // bit_rate_divider
  localparam logic [11:0] OFS_CTRL     = 12'h288;  // serial_control
  localparam logic [11:0] OFS_STATUS   = 12'h28c;  // serial_status
  localparam logic [11:0] OFS_DATA     = 12'h290;  // serial_data_io
  localparam int          LANE_LSB     = 24;       // Registers live in bits 31:24

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG      = 8'h00;    // Writable registers clear at reset; status reads 8'h01
  localparam logic [7:0] CTRL_WR_MASK = 8'hf8;    // Repeat start and reserved read zero
  localparam logic [7:0] RATE_WR_MASK = 8'h3f;    // Bits 7:6 reserved
  localparam logic [7:0] ADDR_WR_MASK = 8'hfe;    // Bit 0 reserved
  localparam int CTL_EN   = 7;                    // Module enable
  localparam int CTL_MSTA = 5;                    // Master select
  localparam int CTL_MTX  = 4;                    // Transmit direction
  localparam int CTL_TXAK = 3;                    // 1 = no acknowledge sent
  localparam int DIV_W    = 12;                   // Divider width
  localparam logic [3:0] BIT_ACK = 4'h8;          // Index of the ninth clock

  // ----------------------------------------------------------------
  // Carriers and state encodings
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;   // Byte offset from module base
    logic [31:0] wdata;  // Write data, register in 31:24
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic        ext;    // Access made by an external bus master
  } reg_req_t;

  typedef enum logic [4:0] {
    M_IDLE  = 5'b00001,
    M_START = 5'b00010,
    M_XFER  = 5'b00100,
    M_WAIT  = 5'b01000,
    M_STOP  = 5'b10000
  } mst_state_t;

  // Rate code to divider, index is the code
  localparam logic [DIV_W-1:0] DIV_TABLE [64] = '{
    12'd28,  12'd30,  12'd34,  12'd40,  12'd44,  12'd48,  12'd56,  12'd68,
    12'd80,  12'd88,  12'd104, 12'd128, 12'd144, 12'd160, 12'd192, 12'd240,
    12'd288, 12'd320, 12'd384, 12'd480, 12'd576, 12'd640, 12'd768, 12'd960,
    12'd1152, 12'd1280, 12'd1536, 12'd1920, 12'd2304, 12'd2560, 12'd3072, 12'd3840,
    12'd20,  12'd22,  12'd24,  12'd26,  12'd28,  12'd32,  12'd36,  12'd40,
    12'd48,  12'd56,  12'd64,  12'd72,  12'd80,  12'd96,  12'd112, 12'd128,
    12'd160, 12'd192, 12'd224, 12'd256, 12'd320, 12'd384, 12'd448, 12'd512,
    12'd640, 12'd768, 12'd896, 12'd1024, 12'd1280, 12'd1536, 12'd1792, 12'd2048
  };

  // Half period of the bit clock for a rate code
  function automatic logic [DIV_W-1:0] half_period(input logic [5:0] code);
    half_period = {1'b0, DIV_TABLE[code][DIV_W-1:1]};
  endfunction : half_period

endpackage : i2c_cfg_pkg

// [sim/i2c_bus_partner.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side of the bus: another master and a plain slave
// ----------------------------------------------------------------
module i2c_bus_partner #(
  parameter int HALF = 50  // Half bit time when this side masters, cycles
) (
  input  wire logic core_clk_i,  // System clock
  input  wire logic scl_i,       // Resolved SCL level
  input  wire logic sda_i,       // Resolved SDA level
  output logic      scl_low_o,   // Pull SCL low
  output logic      sda_low_o    // Pull SDA low
);
  logic       mastering;  // This side owns the frame
  logic       active;     // Frame seen by the responder
  logic [3:0] rises;      // SCL rises in the current byte

  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    mastering = 1'b0;
    active    = 1'b0;
    rises     = 4'h0;
  end

  // Start and stop seen by the responder
  always @(negedge sda_i) if (scl_i && !mastering) begin
    active = 1'b1;
    rises  = 4'h0;
  end
  always @(posedge sda_i) if (scl_i) active = 1'b0;
  always @(posedge scl_i) if (active) rises = rises + 4'h1;

  // Acknowledge every byte; release on the fall that ends the ninth clock
  // Acts at the next falling clock edge, away from the block's sampling edge
  always @(negedge scl_i) begin
    @(negedge core_clk_i);
    if (active && rises == 4'h8) sda_low_o = 1'b1;
    else if (!mastering) sda_low_o = 1'b0;
    if (rises == 4'h9) rises = 4'h0;
  end

  task automatic wait_c(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : wait_c

  // Data changes only in the middle of the low phase
  task automatic put_bit(input logic b);
    scl_low_o = 1'b1;
    wait_c(HALF / 2);
    sda_low_o = ~b;
    wait_c(HALF / 2);
    scl_low_o = 1'b0;
    wait_c(HALF);
  endtask : put_bit

  // Start, one address byte, read the ack, stop
  task automatic send_addr(input logic [7:0] byte_v, output logic ack_n);
    mastering = 1'b1;
    active    = 1'b0;
    sda_low_o = 1'b1;
    wait_c(HALF);
    for (int i = 7; i >= 0; i--) put_bit(byte_v[i]);
    put_bit(1'b1);
    ack_n = sda_i;
    scl_low_o = 1'b1;
    wait_c(HALF / 2);
    sda_low_o = 1'b1;
    wait_c(HALF / 2);
    scl_low_o = 1'b0;
    wait_c(HALF);
    sda_low_o = 1'b0;
    wait_c(HALF);
    mastering = 1'b0;
  endtask : send_addr
endmodule : i2c_bus_partner

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import i2c_cfg_pkg::*;
  // ----------------------------------------------------------------
  // Signals and wire resolution
  // ----------------------------------------------------------------
  logic        core_clk_i;  // 100 MHz clock
  logic        nrst_i;      // Reset, active low
  reg_req_t    req;         // Register request
  logic [31:0] rdata;       // Read data
  logic        bus_ack;     // Access answered
  logic        err;         // Access refused
  logic        scl_oe;      // Block pulls SCL
  logic        sda_oe;      // Block pulls SDA
  logic        m_scl_low;   // Partner pulls SCL
  logic        m_sda_low;   // Partner pulls SDA
  logic        scl_drv;     // Block's SCL drive value
  logic        sda_drv;     // Block's SDA drive value
  wire         scl_w = ~(scl_oe | m_scl_low);  // Pull-up unless pulled low
  wire         sda_w = ~(sda_oe | m_sda_low);
  int          error_cnt;
  int          tests_run;

  i2c_addr_bitrate_cfg u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata),
    .bus_ack_o(bus_ack), .err_o(err), .scl_i(scl_w), .scl_o(scl_drv), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(sda_drv), .sda_oe_o(sda_oe));
  i2c_bus_partner u_bus (.core_clk_i(core_clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl_low),
    .sda_low_o(m_sda_low));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One access; junk in the low lanes must be ignored
  task automatic access(input logic [11:0] a, input logic [7:0] d, input logic wr, output logic [31:0] rd,
                        output logic [1:0] resp);
    @(negedge core_clk_i);
    req = '{addr: a, wdata: {d, 24'ha5c3e1}, wr: wr, rd: !wr, ext: 1'b1};
    @(negedge core_clk_i);
    // Answer stands for one cycle only: take it before it goes
    rd     = rdata;
    resp   = {bus_ack, err};
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask : access

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic [1:0]  resp;
    access(a, d, 1'b1, rd, resp);
    check(resp, 2'b10);
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
    logic [31:0] rd;
    logic [1:0]  resp;
    access(a, 8'h00, 1'b0, rd, resp);
    check(resp, 2'b10);
    check(rd[23:0], 24'h0);
    v = rd[31:24];
  endtask : rd_reg

  // Bounded wait for an SCL level; n counts the cycles spent
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (scl_w !== v && n < 9000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 9000) check(1'b0, 1'b1);
  endtask : wait_lvl

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reg_map();
    logic [11:0] ofs [4];
    logic [7:0]  wv  [4];
    logic [7:0]  ev  [4];
    logic [7:0]  v;
    logic [31:0] rd;
    logic [1:0]  resp;
    ofs = '{OFS_OWN_ADDR, OFS_RATE, OFS_CTRL, OFS_DATA};
    // Reserved bits written as zero
    wv  = '{8'haa, 8'h2a, 8'h0c, 8'h5a};
    ev  = '{8'haa, 8'h2a, 8'h08, 8'h5a};  // Repeat start reads back zero
    rd_reg(OFS_STATUS, v);
    check(v, 8'h01);
    foreach (ofs[i]) wr_reg(ofs[i], wv[i]);
    foreach (ofs[i]) begin
      rd_reg(ofs[i], v);
      check(v, ev[i]);
    end
    access(12'h294, 8'h11, 1'b1, rd, resp);
    check(resp, 2'b11);
    access(12'h27c, 8'h00, 1'b0, rd, resp);
    check(resp, 2'b11);
    check(rd, 32'h0);
    $display("test reg_map done");
  endtask : reg_map

  // Master byte: low phase is half the listed divider, bits from data path
  task automatic master_rate(input logic [5:0] code, input int div);
    logic [7:0] got;
    logic [7:0] v;
    int         n;
    wr_reg(OFS_OWN_ADDR, 8'h54);
    wr_reg(OFS_RATE, {2'b00, code});
    wr_reg(OFS_CTRL, 8'hb0);
    wr_reg(OFS_DATA, 8'ha0);
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    check(n >= div / 2 - 1 && n <= div / 2 + 1, 1'b1);
    got[7] = sda_w;
    for (int i = 6; i >= 0; i--) begin
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      got[i] = sda_w;
    end
    check(got, 8'ha0);
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    repeat (4) @(negedge core_clk_i);
    rd_reg(OFS_STATUS, v);
    check(v & 8'h81, 8'h80);
    wr_reg(OFS_CTRL, 8'h80);
    repeat (2 * div + 10) @(negedge core_clk_i);
    check({scl_w, sda_w}, 2'b11);
    $display("test master_rate %h done", code);
  endtask : master_rate

  // Calling address against own address, enabled and disabled
  task automatic slave_addr();
    logic       ack_n;
    logic [7:0] v;
    wr_reg(OFS_CTRL, 8'h80);
    u_bus.send_addr(8'h55, ack_n);
    check(ack_n, 1'b0);
    check({scl_drv, sda_drv}, 2'b00);
    rd_reg(OFS_STATUS, v);
    check(v & 8'h44, 8'h44);
    wr_reg(OFS_CTRL, 8'h80);
    u_bus.send_addr(8'h56, ack_n);
    check(ack_n, 1'b1);
    wr_reg(OFS_CTRL, 8'h00);
    u_bus.send_addr(8'h54, ack_n);
    check(ack_n, 1'b1);
    $display("test slave_addr done");
  endtask : slave_addr

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    error_cnt = 0;
    tests_run = 0;
    req       = '0;
    nrst_i    = 1'b0;
    repeat (16) @(negedge core_clk_i);
    nrst_i = 1'b1;
    reg_map();
    master_rate(6'h00, 28);
    master_rate(6'h20, 20);
    master_rate(6'h3f, 2048);
    slave_addr();
    final_report();
  end

  // Whole run is about 30k cycles; limit at 60k cycles
  initial begin
    #600000;
    error_cnt++;
    final_report();
  end
endmodule : testbench
